// File: include/wd_pkg.sv
// Constants, timing table and carriers for the pin selectable watchdog
package wd_pkg;
  // Clock and timebase
  localparam int unsigned CLK_FREQ_HZ = 20000000;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned US_PER_S = 1000000;
  localparam int unsigned US_CYCLES = CLK_FREQ_HZ / US_PER_S;
  // Least strobe pulse, rounded up to whole cycles
  localparam int unsigned STROBE_MIN_NS = 100;
  localparam int unsigned STROBE_MIN_CYC = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] FLT_LAST = 2'(STROBE_MIN_CYC - 1);
  // Times in microseconds
  localparam logic [31:0] T_30US = 32'h0000001e;
  localparam logic [31:0] T_200US = 32'h000000c8;
  localparam logic [31:0] SELECT_SETTLE_US = 32'h0000012c; // 300 us
  localparam logic [31:0] T_1MS = 32'h000003e8;
  localparam logic [31:0] T_3MS = 32'h00000bb8;
  localparam logic [31:0] T_10MS = 32'h00002710;
  localparam logic [31:0] T_30MS = 32'h00007530;
  localparam logic [31:0] T_100MS = 32'h000186a0;
  localparam logic [31:0] T_300MS = 32'h000493e0;
  localparam logic [31:0] T_1S = 32'h000f4240;
  localparam logic [31:0] T_3S = 32'h002dc6c0;
  localparam logic [31:0] T_10S = 32'h00989680;
  localparam logic [31:0] T_60S = 32'h03938700;
  localparam logic [31:0] OD_PULSE_US = T_100MS;
  localparam logic [31:0] PP_PULSE_US = T_1MS;
  // Variants and select patterns
  localparam logic [1:0] VAR_EQUAL = 2'h0;
  localparam logic [1:0] VAR_LONG = 2'h1;
  localparam logic [1:0] VAR_FIRST = 2'h2;
  localparam logic [2:0] SEL_DISABLE = 3'h3;
  localparam logic [2:0] SEL_FE_A = 3'h5;
  localparam logic [2:0] SEL_FE_B = 3'h6;
  // Register map
  localparam logic [7:0] CONFIG_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam int unsigned CFG_OD_BIT = 2;
  localparam logic [2:0] CONFIG_RST = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    S_SETTLE, S_STARTUP, S_FIRST_EDGE, S_RUN, S_FAULT, S_DISABLED
  } wd_state_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_t;

  typedef struct packed {
    wd_state_t state;
    logic [31:0] cnt;
    logic [15:0] us_div;
    logic [2:0] sel_s1;
    logic [2:0] sel_s2;
    logic [2:0] sel_applied;
    logic [2:0] cfg;
    logic [2:0] cfg_applied;
    logic strb_s1;
    logic strb_s2;
    logic filt;
    logic [1:0] flt_cnt;
    logic fault_n;
    logic fault_oe;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    axi_rsp_t rsp;
  } wd_regs_t;

  // Startup delay per variant and select pattern
  function automatic logic [31:0] delay_us(input logic [1:0] v, input logic [2:0] s);
    logic [31:0] r;
    r = T_1MS;
    if (v == VAR_LONG) begin
      r = T_60S;
    end else if (v == VAR_FIRST) begin
      case (s)
        3'h0: r = T_3MS;
        3'h1: r = T_3S;
        3'h2: r = T_60S;
        3'h4: r = T_200US;
        default: r = T_60S;
      endcase
    end else begin
      r = timeout_us(v, s);
    end
    return r;
  endfunction

  // Normal timeout per variant and select pattern
  function automatic logic [31:0] timeout_us(input logic [1:0] v, input logic [2:0] s);
    logic [31:0] r;
    r = T_1MS;
    case (s)
      3'h0: r = (v == VAR_FIRST) ? T_3MS : T_1MS;
      3'h1: r = (v == VAR_FIRST) ? T_3S : (v == VAR_LONG) ? T_3MS : T_10MS;
      3'h2: r = (v == VAR_FIRST) ? T_1S : (v == VAR_LONG) ? T_10MS : T_30MS;
      3'h4: r = (v == VAR_FIRST) ? T_30US : T_100MS;
      3'h5: r = (v == VAR_FIRST) ? T_1S : (v == VAR_LONG) ? T_300MS : T_1S;
      3'h6: r = (v == VAR_FIRST) ? T_10S : (v == VAR_LONG) ? T_3S : T_10S;
      3'h7: r = (v == VAR_FIRST) ? T_10S : T_60S;
      default: r = T_1MS;
    endcase
    return r;
  endfunction
endpackage

// File: rtl/pin_selectable_watchdog.sv
// Pin selectable watchdog supervisor with an AXI4-Lite config and status port
//
// Overview of operation
// - Restart timeout on filtered strobe edges, 100ns
// - Ignore strobe during fault pulse and startup
// - Ignore strobe for 300us settle interval
// - Select pins may change while running
// - Change during fault: finish pulse, then settle
// - Change otherwise: adopt now, then settle
// - Pattern 011 disables the watchdog
// - Leaving 011 re-enables after settle
// - Fault output held high while disabled
// - First-edge patterns end startup on strobe edge
// - Open-drain variant fault pulse is 100ms
// - Push-pull variant fault pulse is 1ms
// - After pulse, start fresh full timeout period
// - Missed timeout asserts fault low for pulse
// - Startup delay after power-up or pin change
// - Delays decoded from pins and variant
`timescale 1ns/10ps

module pin_selectable_watchdog #(
  parameter int unsigned us_cycles = wd_pkg::US_CYCLES
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic keepalive_strobe_in,
  input wire logic timing_select_bit0,
  input wire logic timing_select_bit1,
  input wire logic timing_select_bit2,
  output logic timeout_fault_out,
  output logic fault_drive_oe,
  input wire wd_pkg::axi_req_t axi_req,
  output wd_pkg::axi_rsp_t axi_rsp
);

  ////////////////////////////////////////////////////////////////////////////
  // State and helpers

  localparam logic [15:0] US_LAST = 16'(us_cycles - 1);

  wd_pkg::wd_regs_t st;
  wd_pkg::wd_regs_t next_st;

  logic tick;
  logic sel_change;
  logic strobe_edge;
  logic first_edge_mode;
  logic [31:0] startup_hold_period;
  logic [31:0] keepalive_timeout_period;
  logic [31:0] fault_pulse_width;
  logic settle_done;
  logic delay_done;
  logic wd_done;
  logic pulse_done;

  // One microsecond enable from a divider
  // counter timebase
  assign tick = (st.us_div == US_LAST);

  assign sel_change = ({st.cfg, st.sel_s2} != {st.cfg_applied, st.sel_applied});

  assign startup_hold_period = wd_pkg::delay_us(st.cfg_applied[1:0], st.sel_applied);
  assign keepalive_timeout_period = wd_pkg::timeout_us(st.cfg_applied[1:0], st.sel_applied);
  assign first_edge_mode = (st.cfg_applied[1:0] == wd_pkg::VAR_FIRST)
                        && ((st.sel_applied == wd_pkg::SEL_FE_A)
                        || (st.sel_applied == wd_pkg::SEL_FE_B));

  assign fault_pulse_width = st.cfg_applied[wd_pkg::CFG_OD_BIT] ? wd_pkg::OD_PULSE_US
                                                               : wd_pkg::PP_PULSE_US;

  // Period ends land on the tick that completes the last microsecond
  assign settle_done = tick && (st.cnt + 32'h1 >= wd_pkg::SELECT_SETTLE_US);
  assign delay_done = tick && (st.cnt + 32'h1 >= startup_hold_period);
  assign wd_done = tick && (st.cnt + 32'h1 >= keepalive_timeout_period);
  assign pulse_done = tick && (st.cnt + 32'h1 >= fault_pulse_width);

  // a level must hold two cycles (100ns) to count
  assign strobe_edge = (st.strb_s2 != st.filt) && (st.flt_cnt == wd_pkg::FLT_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic restart;
    restart = 1'b0;
    next_st = st;

    // Two flops before any logic reads the pins
    // pin synchronisers
    next_st.sel_s1 = {timing_select_bit2, timing_select_bit1, timing_select_bit0};
    next_st.sel_s2 = st.sel_s1;
    next_st.strb_s1 = keepalive_strobe_in;
    next_st.strb_s2 = st.strb_s1;

    // Glitch filter; shorter pulses never move the filtered level
    // pulse width filter
    if (st.strb_s2 == st.filt) begin
      next_st.flt_cnt = 2'h0;
    end else if (strobe_edge) begin
      next_st.filt = st.strb_s2;
      next_st.flt_cnt = 2'h0;
    end else begin
      next_st.flt_cnt = st.flt_cnt + 2'h1;
    end

    // Free running microsecond count, cleared on every phase change
    if (tick) begin
      next_st.us_div = 16'h0000;
      next_st.cnt = st.cnt + 32'h1;
    end else begin
      next_st.us_div = st.us_div + 16'h0001;
    end

    case (st.state)
      wd_pkg::S_SETTLE: begin
        if (sel_change) begin
          next_st.sel_applied = st.sel_s2;
          next_st.cfg_applied = st.cfg;
          restart = 1'b1;
        end else if (settle_done) begin
          restart = 1'b1;
          if (st.sel_applied == wd_pkg::SEL_DISABLE) begin
            next_st.state = wd_pkg::S_DISABLED;
          end else if (first_edge_mode) begin
            next_st.state = wd_pkg::S_FIRST_EDGE;
          end else begin
            next_st.state = wd_pkg::S_STARTUP;
          end
        end
      end
      wd_pkg::S_STARTUP: begin
        if (sel_change) begin
          next_st.sel_applied = st.sel_s2;
          next_st.cfg_applied = st.cfg;
          next_st.state = wd_pkg::S_SETTLE;
          restart = 1'b1;
        end else if (delay_done) begin
          next_st.state = wd_pkg::S_RUN;
          restart = 1'b1;
        end
      end
      wd_pkg::S_FIRST_EDGE: begin
        // no deadline on the first edge
        if (sel_change) begin
          next_st.sel_applied = st.sel_s2;
          next_st.cfg_applied = st.cfg;
          next_st.state = wd_pkg::S_SETTLE;
          restart = 1'b1;
        end else if (strobe_edge) begin
          next_st.state = wd_pkg::S_RUN;
          restart = 1'b1;
        end
      end
      wd_pkg::S_RUN: begin
        if (sel_change) begin
          next_st.sel_applied = st.sel_s2;
          next_st.cfg_applied = st.cfg;
          next_st.state = wd_pkg::S_SETTLE;
          restart = 1'b1;
        end else if (strobe_edge) begin
          restart = 1'b1;
        end else if (wd_done) begin
          next_st.state = wd_pkg::S_FAULT;
          restart = 1'b1;
        end
      end
      wd_pkg::S_FAULT: begin
        if (pulse_done) begin
          restart = 1'b1;
          if (sel_change) begin
            next_st.sel_applied = st.sel_s2;
            next_st.cfg_applied = st.cfg;
            next_st.state = wd_pkg::S_SETTLE;
          end else begin
            next_st.state = wd_pkg::S_RUN;
          end
        end
      end
      wd_pkg::S_DISABLED: begin
        if (sel_change) begin
          next_st.sel_applied = st.sel_s2;
          next_st.cfg_applied = st.cfg;
          next_st.state = wd_pkg::S_SETTLE;
          restart = 1'b1;
        end
      end
      default: begin
        next_st.state = wd_pkg::S_SETTLE;
        restart = 1'b1;
      end
    endcase

    if (restart) begin
      next_st.cnt = 32'h0;
      next_st.us_div = 16'h0000;
    end

    // Fault line follows the next state, so the pin flop is the state flop
    // output drive
    next_st.fault_n = (next_st.state != wd_pkg::S_FAULT);
    next_st.fault_oe = !next_st.fault_n && next_st.cfg_applied[wd_pkg::CFG_OD_BIT];

    // Write side: address and data taken in either order
    if (axi_req.awvalid && st.rsp.awready) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st.rsp.wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = axi_req.wdata;
      next_st.wstrb = axi_req.wstrb;
    end
    if (st.rsp.bvalid && axi_req.bready) begin
      next_st.rsp.bvalid = 1'b0;
    end
    if (st.aw_got && st.w_got && !st.rsp.bvalid) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.rsp.bvalid = 1'b1;
      next_st.rsp.bresp = wd_pkg::RESP_OKAY;
      if (st.awaddr == wd_pkg::CONFIG_ADDR) begin
        if (st.wstrb[0]) begin
          next_st.cfg = st.wdata[2:0];
        end
      end else if (st.awaddr == wd_pkg::STATUS_ADDR) begin
        next_st.rsp.bresp = wd_pkg::RESP_OKAY;
      end else begin
        next_st.rsp.bresp = wd_pkg::RESP_SLVERR;
      end
    end
    // Ready drops while a word is held, which back-pressures the master
    next_st.rsp.awready = !next_st.aw_got && !next_st.rsp.bvalid;
    next_st.rsp.wready = !next_st.w_got && !next_st.rsp.bvalid;

    // Read side
    if (st.rsp.rvalid && axi_req.rready) begin
      next_st.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && st.rsp.arready) begin
      next_st.rsp.rvalid = 1'b1;
      next_st.rsp.rresp = wd_pkg::RESP_OKAY;
      next_st.rsp.rdata = 32'h0;
      if (axi_req.araddr == wd_pkg::CONFIG_ADDR) begin
        next_st.rsp.rdata = {29'h0, st.cfg};
      end else if (axi_req.araddr == wd_pkg::STATUS_ADDR) begin
        next_st.rsp.rdata = {24'h0, st.filt, st.sel_applied, !st.fault_n, st.state};
      end else begin
        next_st.rsp.rresp = wd_pkg::RESP_SLVERR;
      end
    end
    next_st.rsp.arready = !next_st.rsp.rvalid;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Reset lands in settle, as after power-up
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.fault_n <= 1'b1;
      st.cfg <= wd_pkg::CONFIG_RST;
      st.cfg_applied <= wd_pkg::CONFIG_RST;
    end else begin
      st <= next_st;
    end
  end

  assign timeout_fault_out = st.fault_n;
  assign fault_drive_oe = st.fault_oe;
  assign axi_rsp = st.rsp;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_filter_restart;
    @(posedge sys_clk) disable iff (!arst_n)
    (st.state == wd_pkg::S_RUN && strobe_edge && !sel_change)
      |=> (st.cnt == 32'h0 && st.us_div == 16'h0000 && st.state == wd_pkg::S_RUN);
  endproperty
  a_filter_restart: assert property (p_filter_restart)
    else $error("valid strobe edge did not restart timeout");

  property p_short_pulse;
    @(posedge sys_clk) disable iff (!arst_n)
    (st.strb_s2 != st.filt && st.flt_cnt == 2'h0) ##1 (st.strb_s2 == st.filt)
      |-> $stable(st.filt);
  endproperty
  a_short_pulse: assert property (p_short_pulse)
    else $error("one cycle strobe glitch was accepted");

  property p_startup_ignores;
    @(posedge sys_clk) disable iff (!arst_n)
    (st.state == wd_pkg::S_STARTUP && !delay_done && !sel_change)
      |=> (st.state == wd_pkg::S_STARTUP);
  endproperty
  a_startup_ignores: assert property (p_startup_ignores)
    else $error("startup left early");

  property p_settle_ignores;
    @(posedge sys_clk) disable iff (!arst_n)
    (st.state == wd_pkg::S_SETTLE && strobe_edge && !settle_done && !sel_change)
      |=> (st.state == wd_pkg::S_SETTLE && st.cnt >= $past(st.cnt));
  endproperty
  a_settle_ignores: assert property (p_settle_ignores)
    else $error("strobe acted during settle");

  property p_fault_finishes;
    @(posedge sys_clk) disable iff (!arst_n)
    (st.state == wd_pkg::S_FAULT && !pulse_done) |=> (st.state == wd_pkg::S_FAULT);
  endproperty
  a_fault_finishes: assert property (p_fault_finishes)
    else $error("fault pulse cut short");

  property p_change_settles;
    @(posedge sys_clk) disable iff (!arst_n)
    (st.state == wd_pkg::S_RUN && sel_change)
      |=> (st.state == wd_pkg::S_SETTLE && st.sel_applied == $past(st.sel_s2));
  endproperty
  a_change_settles: assert property (p_change_settles)
    else $error("pin change not adopted");

  property p_disable;
    @(posedge sys_clk) disable iff (!arst_n)
    (st.state == wd_pkg::S_SETTLE && settle_done && !sel_change
      && st.sel_applied == wd_pkg::SEL_DISABLE) |=> (st.state == wd_pkg::S_DISABLED);
  endproperty
  a_disable: assert property (p_disable)
    else $error("disable pattern not honoured");

  property p_disabled_high;
    @(posedge sys_clk) disable iff (!arst_n)
    (st.state == wd_pkg::S_DISABLED) |-> (timeout_fault_out && !fault_drive_oe);
  endproperty
  a_disabled_high: assert property (p_disabled_high)
    else $error("fault output low while disabled");

  property p_fresh_timeout;
    @(posedge sys_clk) disable iff (!arst_n)
    (st.state == wd_pkg::S_FAULT ##1 st.state == wd_pkg::S_RUN)
      |-> (st.cnt == 32'h0 && timeout_fault_out);
  endproperty
  a_fresh_timeout: assert property (p_fresh_timeout)
    else $error("timeout not restarted after pulse");

  property p_fault_cause;
    @(posedge sys_clk) disable iff (!arst_n)
    $fell(timeout_fault_out) |-> $past(st.state == wd_pkg::S_RUN && wd_done);
  endproperty
  a_fault_cause: assert property (p_fault_cause)
    else $error("fault asserted without a timeout");

endmodule

// File: dv/keepalive_host.sv
// Behavioural processor that strobes the watchdog keepalive pin
`timescale 1ns/10ps

module keepalive_host (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic run,
  input wire logic glitch,
  input wire logic kick,
  input wire logic [7:0] half,
  output logic strobe
);
  logic lvl;
  logic blip;
  logic [7:0] cnt;

  ////////////////////////////////////////////////////////////////////////////////
  // level set apart
  // Level flips at separate points, so a stalled loop stops the strobe
  // kick before change
  // A kick is one toggle issued just before the select pins move
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lvl <= 1'b0;
      blip <= 1'b0;
      cnt <= 8'h00;
    end else begin
      blip <= 1'b0;
      if (kick) begin
        lvl <= ~lvl;
      end else if (run && cnt >= half) begin
        cnt <= 8'h00;
        // Glitch mode: one-cycle blips, narrower than a valid strobe
        if (glitch) begin
          blip <= 1'b1;
        end else begin
          lvl <= ~lvl;
        end
      end else if (run) begin
        cnt <= cnt + 8'h01;
      end
    end
  end

  // Pin is actively driven both ways, so it holds its level when idle
  assign strobe = lvl ^ blip;
endmodule

// File: dv/testbench.sv
// Self-checking bench for the pin selectable watchdog
`timescale 1ns/10ps

module testbench;
  localparam int unsigned USC = 1;
  localparam int SETL = int'(wd_pkg::SELECT_SETTLE_US) * USC;
  localparam int DLY = int'(wd_pkg::T_200US) * USC;
  localparam int TOUT = int'(wd_pkg::T_30US) * USC;
  localparam int PP = int'(wd_pkg::PP_PULSE_US) * USC;
  localparam int FIRST = SETL + DLY + TOUT;
  logic sys_clk;
  logic arst_n;
  logic [2:0] sel;
  logic strobe;
  logic fault_n;
  logic fault_oe;
  wd_pkg::axi_req_t req;
  wd_pkg::axi_rsp_t rsp;
  logic run;
  logic glitch;
  logic kick;
  logic [7:0] half;
  logic [31:0] rd_data;
  logic [1:0] resp;
  int err_total;
  int n_compared;
  int n;
  int cyc;
  int t0;

  pin_selectable_watchdog #(.us_cycles(USC)) dut (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .keepalive_strobe_in(strobe),
    .timing_select_bit0(sel[0]),
    .timing_select_bit1(sel[1]),
    .timing_select_bit2(sel[2]),
    .timeout_fault_out(fault_n),
    .fault_drive_oe(fault_oe),
    .axi_req(req),
    .axi_rsp(rsp)
  );

  keepalive_host host (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .run(run),
    .glitch(glitch),
    .kick(kick),
    .half(half),
    .strobe(strobe)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and free-running cycle count for interval checks
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict, comparisons and bounded waits
  task automatic complete_run;
    if (err_total == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_rng(input int got, input int lo, input int hi, input string what);
    n_compared++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("mismatch at %0t: %s took %0d, window %0d..%0d", $time, what, got, lo, hi);
    end
  endtask

  task automatic hang(input string what);
    err_total++;
    $display("mismatch at %0t: %s timed out", $time, what);
    complete_run();
  endtask

  // Edges until the fault pin shows lvl; returns lim if it never does
  task automatic watch(input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while (cnt < lim && fault_n !== lvl) begin
      @(posedge sys_clk);
      cnt++;
    end
  endtask

  // Same wait, but the event is required
  task automatic need(input logic lvl, input int lim, output int cnt);
    watch(lvl, lim, cnt);
    if (cnt == lim) hang("fault pin");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite master: hold each channel until its own handshake
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    r = 2'h1;
    @(posedge sys_clk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge sys_clk);
      if (req.awvalid && rsp.awready === 1'b1) begin
        req.awvalid <= 1'b0;
      end
      if (req.wvalid && rsp.wready === 1'b1) begin
        req.wvalid <= 1'b0;
      end
      if (req.bready && rsp.bvalid === 1'b1) begin
        r = rsp.bresp;
        req.bready <= 1'b0;
        break;
      end
    end
    if (k == 64) hang("write");
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    r = 2'h1;
    d = 32'h0;
    @(posedge sys_clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge sys_clk);
      if (req.arvalid && rsp.arready === 1'b1) begin
        req.arvalid <= 1'b0;
      end
      if (req.rready && rsp.rvalid === 1'b1) begin
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
        break;
      end
    end
    if (k == 64) hang("read");
  endtask

  // State and applied select from the status word
  task automatic chk_state(input logic [2:0] st, input logic [2:0] s);
    axi_rd(wd_pkg::STATUS_ADDR, rd_data, resp);
    cmp_val({25'h0, rd_data[6:0]}, {25'h0, s, st == 3'h4, st}, "status");
  endtask

  task automatic kick_once;
    @(posedge sys_clk);
    kick <= 1'b1;
    @(posedge sys_clk);
    kick <= 1'b0;
  endtask

  task automatic set_sel(input logic [2:0] s);
    kick_once();
    repeat (8) @(posedge sys_clk);
    sel <= s;
    t0 = cyc;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(32'hbf6f5693));
    arst_n = 1'b0;
    req = '0;
    sel = 3'h4;
    run = 1'b0;
    glitch = 1'b0;
    kick = 1'b0;
    half = 8'h0a;
    cyc = 0;
    err_total = 0;
    n_compared = 0;
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    // Reset values, unmapped places, read-only status
    axi_rd(wd_pkg::CONFIG_ADDR, rd_data, resp);
    cmp_val(rd_data, 32'h0, "config reset");
    chk_state(3'h0, 3'h4);
    axi_rd(8'h08, rd_data, resp);
    cmp_val({30'h0, resp}, {30'h0, wd_pkg::RESP_SLVERR}, "unmapped read");
    axi_wr(8'h0c, 32'h2, resp);
    cmp_val({30'h0, resp}, {30'h0, wd_pkg::RESP_SLVERR}, "unmapped write");
    axi_wr(wd_pkg::STATUS_ADDR, 32'hff, resp);
    cmp_val({30'h0, resp}, {30'h0, wd_pkg::RESP_OKAY}, "status write");
    // First-edge family, pattern 100: settle, timed delay, short timeout
    axi_wr(wd_pkg::CONFIG_ADDR, 32'h2, resp);
    t0 = cyc;
    need(1'b0, 700, n);
    cmp_rng(cyc - t0, FIRST - 2, FIRST + 8, "first fault");
    cmp_val({31'h0, fault_oe}, 32'h0, "push-pull oe");
    need(1'b1, PP + 100, n);
    cmp_rng(n, PP, PP + 1, "pulse width");
    need(1'b0, 100, n);
    cmp_rng(n, TOUT - 1, TOUT + 2, "timeout after pulse");
    // Strobes during the pulse do not shorten it
    half <= 8'($urandom_range(12, 5));
    run <= 1'b1;
    need(1'b1, PP + 100, n);
    cmp_rng(n, PP - 1, PP + 1, "pulse with strobes");
    watch(1'b0, 2000, n);
    cmp_rng(n, 2000, 2000, "kept alive");
    // Blips narrower than a valid strobe are ignored
    glitch <= 1'b1;
    watch(1'b0, 80, n);
    cmp_rng(n, 1, 79, "narrow blips");
    glitch <= 1'b0;
    run <= 1'b0;
    // Disable requested mid-pulse: pulse completes, then resettle
    set_sel(wd_pkg::SEL_DISABLE);
    need(1'b1, PP + 100, n);
    cmp_rng(n, PP - 12, PP - 8, "pulse after change");
    chk_state(3'h0, wd_pkg::SEL_DISABLE);
    repeat (SETL + 20) @(posedge sys_clk);
    chk_state(3'h5, wd_pkg::SEL_DISABLE);
    watch(1'b0, 3000, n);
    cmp_rng(n, 3000, 3000, "disabled");
    set_sel(wd_pkg::SEL_FE_A);
    repeat (SETL + 20) @(posedge sys_clk);
    chk_state(3'h2, wd_pkg::SEL_FE_A);
    watch(1'b0, 2000, n);
    cmp_rng(n, 2000, 2000, "first-edge wait");
    kick_once();
    repeat (10) @(posedge sys_clk);
    chk_state(3'h3, wd_pkg::SEL_FE_A);
    // Change while running takes effect at once
    half <= 8'($urandom_range(20, 5));
    run <= 1'b1;
    repeat ($urandom_range(200, 50)) @(posedge sys_clk);
    set_sel(3'h4);
    repeat (6) @(posedge sys_clk);
    chk_state(3'h0, 3'h4);
    run <= 1'b0;
    need(1'b0, 700, n);
    cmp_rng(cyc - t0, FIRST, FIRST + 10, "fault after change");
    need(1'b1, PP + 100, n);
    // Open-drain output: enable drives, pulse outlasts push-pull
    axi_wr(wd_pkg::CONFIG_ADDR, 32'h6, resp);
    t0 = cyc;
    need(1'b0, 700, n);
    cmp_rng(cyc - t0, FIRST - 2, FIRST + 8, "open-drain fault");
    cmp_val({31'h0, fault_oe}, 32'h1, "oe on");
    repeat (PP + PP / 2) @(posedge sys_clk);
    cmp_val({30'h0, fault_oe, fault_n}, 32'h2, "long pulse");
    // Second reset in mid-pulse
    arst_n <= 1'b0;
    repeat (16) @(posedge sys_clk);
    cmp_val({30'h0, fault_oe, fault_n}, 32'h1, "reset outputs");
    arst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    axi_rd(wd_pkg::CONFIG_ADDR, rd_data, resp);
    cmp_val(rd_data, 32'h0, "config after reset");
    // Equal variant, pattern 000: delay equals the 1ms timeout
    set_sel(3'h0);
    need(1'b0, SETL + 2 * PP + 100, n);
    cmp_rng(cyc - t0, SETL + 2 * PP, SETL + 2 * PP + 10, "equal variant fault");
    cmp_val({31'h0, fault_oe}, 32'h0, "push-pull after reset");
    need(1'b1, PP + 100, n);
    // Long variant: 60s delay still running where a 1ms delay would be over
    axi_wr(wd_pkg::CONFIG_ADDR, 32'h1, resp);
    repeat (SETL + PP + 200) @(posedge sys_clk);
    chk_state(3'h1, 3'h0);
    complete_run();
  end
endmodule
